// ### include/ttpc_pkg.sv
// ttpc_pkg: register map, field layout, timing constants and protocol states of the protocol core
package ttpc_pkg;
  localparam int ADDR_W = 8;
  localparam int CLK_NS = 10;
  localparam int WAKE_LOW_NS = 6000;
  localparam int WAKE_IDLE_NS = 18000;
  localparam int WAKE_LOW_CYC = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_IDLE_CYC = (WAKE_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_NODE_LIMIT = 16;
  localparam logic [15:0] IDLE_MIN = 16'h0004;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IDLE = 8'h0C;
  localparam logic [7:0] OFS_OFFS_LIM = 8'h10;
  localparam logic [7:0] OFS_RATE_LIM = 8'h14;
  localparam logic [7:0] OFS_EXT_OFFS = 8'h18;
  localparam logic [7:0] OFS_EXT_RATE = 8'h1C;
  localparam logic [7:0] OFS_FID_FILT = 8'h20;
  localparam logic [7:0] OFS_CYC_FILT = 8'h24;
  localparam logic [7:0] OFS_MID_FILT = 8'h28;
  localparam logic [7:0] OFS_MT = 8'h2C;
  localparam logic [7:0] OFS_TIMER = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  localparam logic [7:0] OFS_CORR = 8'h3C;
  localparam logic [7:0] OFS_MEAS_SEL = 8'h40;
  localparam logic [7:0] OFS_MEAS_DATA = 8'h44;
  localparam int CTRL_INHIBIT = 0;
  localparam int CTRL_WAKE_A = 1;
  localparam int CTRL_WAKE_B = 2;
  localparam int CTRL_FIFO = 3;
  localparam int CTRL_REP_LSB = 4;
  localparam int CTRL_ATT_LSB = 8;
  localparam logic [11:0] CTRL_RST = 12'h822;
  localparam logic [15:0] IDLE_RST = 16'h0010;
  localparam logic [15:0] LIM_RST = 16'h0100;
  localparam int IRQ_TIMER = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_RX = 3;
  localparam logic [2:0] CMD_CONFIG = 3'h1;
  localparam logic [2:0] CMD_READY = 3'h2;
  localparam logic [2:0] CMD_WAKEUP = 3'h3;
  localparam logic [2:0] CMD_RUN = 3'h4;
  typedef enum logic [2:0] {
    ST_PROT_RESET, ST_CONFIG, ST_READY, ST_WAKE_SEND,
    ST_CS_LISTEN, ST_INT_LISTEN, ST_INIT_SCHED, ST_NORMAL
  } ttpc_state_e;
endpackage

// ### core/ttpc_core.sv
// ttpc_core: protocol operation control, clock-sync bookkeeping, receive filtering and APB registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
module ttpc_core #(
  parameter int MEAS_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ttpc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_cycle_start,
  input wire logic i_cycle_odd,
  input wire logic i_nit_start,
  input wire logic i_mt_tick,
  input wire logic i_mt_reset,
  input wire logic i_rx_valid,
  input wire logic i_rx_chan,
  input wire logic i_rx_startup_ind,
  input wire logic i_rx_sync_ind,
  input wire logic i_rx_null_ind,
  input wire logic [10:0] i_rx_frame_id,
  input wire logic [5:0] i_rx_cycle,
  input wire logic [15:0] i_rx_msg_id,
  input wire logic [31:0] i_rx_data,
  input wire logic i_meas_valid,
  input wire logic [MEAS_W-1:0] i_meas_value,
  input wire logic i_coldstart_fail,
  input wire logic i_integrated,
  input wire logic i_corr_calc,
  input wire logic [15:0] i_offs_raw,
  input wire logic [15:0] i_rate_raw,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_wake_tx_a,
  output logic o_wake_tx_b,
  output logic o_rx_buf_we,
  output logic o_rx_fifo_we,
  output logic [10:0] o_rx_frame_id,
  output logic [31:0] o_rx_data,
  output logic [15:0] o_offs_corr,
  output logic [15:0] o_rate_corr,
  output logic [15:0] o_idle_len,
  output logic o_coldstart_inhibit,
  output ttpc_pkg::ttpc_state_e o_state
);
  import ttpc_pkg::*;

  if (MEAS_W < 8 || MEAS_W > 32) begin : g_bad_width
    $error("ttpc_core: MEAS_W must lie in 8..32");
  end

  function automatic logic fmatch(input logic [15:0] v, input logic [15:0] val, input logic [15:0] mask);
    return ((v ^ val) & mask) == 16'h0000;
  endfunction

  // symmetric saturation against a positive limit
  function automatic logic [15:0] lim_chk(input logic [15:0] raw, input logic [15:0] lim);
    if ($signed(raw) > $signed(lim)) begin
      return lim;
    end else if ($signed(raw) < -$signed(lim)) begin
      return 16'(-$signed(lim));
    end
    return raw;
  endfunction

  ttpc_state_e state, next_state;
  logic wake_ch_a, wake_ch_b, fifo_route;
  logic [3:0] wake_rep, cs_att_cfg, att_left, irq_stat, irq_mask, wk_rep;
  logic [15:0] offs_lim, rate_lim, ext_offs, ext_rate, mid_val, mid_mask, mt_value, timer_cmp;
  logic [10:0] fid_val, fid_mask;
  logic [5:0] cyc_val, cyc_mask;
  logic [1:0] ch_en;
  logic [4:0] meas_sel, su_cnt_a, su_cnt_b, su_max;
  logic [MEAS_W-1:0] meas [2][SYNC_NODE_LIMIT];
  logic [4:0] meas_cnt [2];
  logic [11:0] wk_cnt;
  logic wk_low, disp_hold;
  logic acc, wr_en, rd_en, mapped;
  logic [2:0] cmd;
  logic [31:0] rdata_c;
  logic wake_done, last_fail, startup_phase, rx_ok, timer_hit, corr_err, cfg_err;
  logic [3:0] irq_set;

  assign acc = i_psel & i_penable;
  assign wr_en = acc & o_pready & i_pwrite;
  assign rd_en = acc & o_pready & ~i_pwrite;
  assign cmd = (wr_en && i_paddr == OFS_CMD) ? i_pwdata[2:0] : 3'h0;
  assign su_max = (su_cnt_a > su_cnt_b) ? su_cnt_a : su_cnt_b;
  assign startup_phase = state inside {ST_CS_LISTEN, ST_INT_LISTEN, ST_INIT_SCHED};
  assign wake_done = state == ST_WAKE_SEND && !wk_low && wk_cnt == 12'(WAKE_IDLE_CYC - 1) && wk_rep <= 4'h1;
  assign last_fail = state == ST_CS_LISTEN && i_coldstart_fail && !i_integrated && att_left <= 4'h1;
  assign timer_hit = i_mt_tick && !i_mt_reset && mt_value == timer_cmp;

  // APB slave: access phase always takes two cycles, pready in the second
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= acc & ~o_pready;
      o_pslverr <= acc & ~o_pready & ~mapped;
      if (acc && !o_pready && !i_pwrite) begin
        o_prdata <= rdata_c;
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdata_c = 32'h0000_0000;
    case (i_paddr)
      OFS_CTRL: rdata_c = {20'h0_0000, cs_att_cfg, wake_rep, fifo_route, wake_ch_b, wake_ch_a, o_coldstart_inhibit};
      OFS_CMD: rdata_c = 32'h0000_0000;
      OFS_STATUS: rdata_c = {19'h0_0000, su_max, 5'h00, 3'(o_state)};
      OFS_IDLE: rdata_c = {16'h0000, o_idle_len};
      OFS_OFFS_LIM: rdata_c = {16'h0000, offs_lim};
      OFS_RATE_LIM: rdata_c = {16'h0000, rate_lim};
      OFS_EXT_OFFS: rdata_c = {16'h0000, ext_offs};
      OFS_EXT_RATE: rdata_c = {16'h0000, ext_rate};
      OFS_FID_FILT: rdata_c = {5'h00, fid_mask, 5'h00, fid_val};
      OFS_CYC_FILT: rdata_c = {14'h0000, ch_en, 2'h0, cyc_mask, 2'h0, cyc_val};
      OFS_MID_FILT: rdata_c = {mid_mask, mid_val};
      OFS_MT: rdata_c = {16'h0000, mt_value};
      OFS_TIMER: rdata_c = {16'h0000, timer_cmp};
      OFS_IRQ_STAT: rdata_c = {28'h000_0000, irq_stat};
      OFS_IRQ_MASK: rdata_c = {28'h000_0000, irq_mask};
      OFS_CORR: rdata_c = {o_rate_corr, o_offs_corr};
      OFS_MEAS_SEL: rdata_c = {27'h000_0000, meas_sel};
      OFS_MEAS_DATA: rdata_c = 32'(meas[meas_sel[4]][meas_sel[3:0]]);
      default: mapped = 1'b0;
    endcase
  end

  // configuration registers
  always_ff @(posedge i_mclk) begin
    cfg_err <= 1'b0;
    if (i_srst) begin
      {cs_att_cfg, wake_rep, fifo_route, wake_ch_b, wake_ch_a, o_coldstart_inhibit} <= CTRL_RST;
      o_idle_len <= IDLE_RST;
      offs_lim <= LIM_RST;
      rate_lim <= LIM_RST;
      ext_offs <= 16'h0000;
      ext_rate <= 16'h0000;
      {fid_mask, fid_val} <= 22'h00_0000;
      {ch_en, cyc_mask, cyc_val} <= 14'h3000;
      {mid_mask, mid_val} <= 32'h0000_0000;
      timer_cmp <= 16'h0000;
      irq_mask <= 4'h0;
      meas_sel <= 5'h00;
    end else if (wr_en) begin
      case (i_paddr)
        OFS_CTRL: begin
          cs_att_cfg <= i_pwdata[CTRL_ATT_LSB +: 4];
          wake_rep <= i_pwdata[CTRL_REP_LSB +: 4];
          fifo_route <= i_pwdata[CTRL_FIFO];
          wake_ch_b <= i_pwdata[CTRL_WAKE_B];
          wake_ch_a <= i_pwdata[CTRL_WAKE_A];
          // a clear only sticks while still in the protocol reset state
          if (state == ST_PROT_RESET) begin
            o_coldstart_inhibit <= i_pwdata[CTRL_INHIBIT];
          end else begin
            o_coldstart_inhibit <= o_coldstart_inhibit | i_pwdata[CTRL_INHIBIT];
          end
        end
        OFS_IDLE: begin
          if (i_pwdata[15:0] < IDLE_MIN) begin
            cfg_err <= 1'b1;
          end else begin
            o_idle_len <= i_pwdata[15:0];
          end
        end
        OFS_OFFS_LIM: offs_lim <= i_pwdata[15:0];
        OFS_RATE_LIM: rate_lim <= i_pwdata[15:0];
        OFS_EXT_OFFS: ext_offs <= i_pwdata[15:0];
        OFS_EXT_RATE: ext_rate <= i_pwdata[15:0];
        OFS_FID_FILT: {fid_mask, fid_val} <= {i_pwdata[26:16], i_pwdata[10:0]};
        OFS_CYC_FILT: {ch_en, cyc_mask, cyc_val} <= {i_pwdata[17:16], i_pwdata[13:8], i_pwdata[5:0]};
        OFS_MID_FILT: {mid_mask, mid_val} <= i_pwdata;
        OFS_TIMER: timer_cmp <= i_pwdata[15:0];
        OFS_IRQ_MASK: irq_mask <= i_pwdata[3:0];
        OFS_MEAS_SEL: meas_sel <= i_pwdata[4:0];
        default: ;
      endcase
    end
  end

  // protocol operation control; unknown commands are ignored, there is no sleep command
  always_comb begin
    next_state = state;
    case (state)
      ST_PROT_RESET: if (cmd == CMD_CONFIG) next_state = ST_CONFIG;
      ST_CONFIG: if (cmd == CMD_READY) next_state = ST_READY;
      ST_READY: begin
        if (cmd == CMD_WAKEUP) begin
          next_state = ST_WAKE_SEND;
        end else if (cmd == CMD_RUN) begin
          next_state = (o_coldstart_inhibit || cs_att_cfg == 4'h0) ? ST_INT_LISTEN : ST_CS_LISTEN;
        end else if (cmd == CMD_CONFIG) begin
          next_state = ST_CONFIG;
        end
      end
      ST_WAKE_SEND: if (wake_done) next_state = ST_CONFIG;
      ST_CS_LISTEN: begin
        if (i_integrated) begin
          next_state = ST_INIT_SCHED;
        end else if (last_fail) begin
          next_state = ST_INT_LISTEN;
        end
      end
      ST_INT_LISTEN: if (i_integrated) next_state = ST_INIT_SCHED;
      ST_INIT_SCHED: if (i_cycle_start) next_state = ST_NORMAL;
      ST_NORMAL: next_state = ST_NORMAL;
      default: next_state = ST_PROT_RESET;
    endcase
    if (cmd == CMD_CONFIG && state inside {ST_CS_LISTEN, ST_INT_LISTEN, ST_INIT_SCHED, ST_NORMAL}) begin
      next_state = ST_CONFIG;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= ST_PROT_RESET;
      o_state <= ST_PROT_RESET;
      disp_hold <= 1'b0;
      att_left <= 4'h0;
    end else begin
      state <= next_state;
      // host view lags the real state by one macrotick after the last failed coldstart
      disp_hold <= last_fail | (disp_hold & ~i_mt_tick & next_state == ST_INT_LISTEN);
      o_state <= (last_fail || (disp_hold && !i_mt_tick && next_state == ST_INT_LISTEN)) ? ST_CS_LISTEN : next_state;
      if (state == ST_READY && cmd == CMD_RUN) begin
        att_left <= cs_att_cfg;
      end else if (state == ST_CS_LISTEN && i_coldstart_fail && att_left != 4'h0) begin
        att_left <= att_left - 4'h1;
      end
    end
  end

  // wakeup pattern: low phase then idle phase, repeated; transmit only, no receive path
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wk_cnt <= 12'h000;
      wk_rep <= 4'h0;
      wk_low <= 1'b0;
      o_wake_tx_a <= 1'b0;
      o_wake_tx_b <= 1'b0;
    end else begin
      if (state == ST_READY && cmd == CMD_WAKEUP) begin
        wk_cnt <= 12'h000;
        wk_rep <= (wake_rep == 4'h0) ? 4'h1 : wake_rep;
        wk_low <= 1'b1;
      end else if (state == ST_WAKE_SEND) begin
        if (wk_low && wk_cnt == 12'(WAKE_LOW_CYC - 1)) begin
          wk_low <= 1'b0;
          wk_cnt <= 12'h000;
        end else if (!wk_low && wk_cnt == 12'(WAKE_IDLE_CYC - 1)) begin
          wk_low <= wk_rep > 4'h1;
          wk_rep <= wk_rep - 4'h1;
          wk_cnt <= 12'h000;
        end else begin
          wk_cnt <= wk_cnt + 12'h001;
        end
      end else begin
        wk_low <= 1'b0;
      end
      o_wake_tx_a <= state == ST_WAKE_SEND && wk_low && wake_ch_a;
      o_wake_tx_b <= state == ST_WAKE_SEND && wk_low && wake_ch_b;
    end
  end

  // receive delivery; the startup indicator is only counted, never forwarded
  assign rx_ok = i_rx_valid && i_rx_null_ind && !startup_phase && ch_en[i_rx_chan]
    && fmatch({5'h00, i_rx_frame_id}, {5'h00, fid_val}, {5'h00, fid_mask})
    && fmatch({10'h000, i_rx_cycle}, {10'h000, cyc_val}, {10'h000, cyc_mask});

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rx_buf_we <= 1'b0;
      o_rx_fifo_we <= 1'b0;
      o_rx_frame_id <= 11'h000;
      o_rx_data <= 32'h0000_0000;
    end else begin
      o_rx_buf_we <= rx_ok && !fifo_route;
      o_rx_fifo_we <= rx_ok && fifo_route && fmatch(i_rx_msg_id, mid_val, mid_mask);
      if (rx_ok) begin
        o_rx_frame_id <= i_rx_frame_id;
        o_rx_data <= i_rx_data;
      end
    end
  end

  // per-channel startup frame counters, restarted every cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_cycle_start) begin
      su_cnt_a <= 5'h00;
      su_cnt_b <= 5'h00;
    end else if (i_rx_valid && i_rx_startup_ind && i_rx_sync_ind) begin
      if (!i_rx_chan && su_cnt_a != 5'(SYNC_NODE_LIMIT)) su_cnt_a <= su_cnt_a + 5'h01;
      if (i_rx_chan && su_cnt_b != 5'(SYNC_NODE_LIMIT)) su_cnt_b <= su_cnt_b + 5'h01;
    end
  end

  // measurement tables; clearing ahead of the cycle keeps clear and store off the same entry
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meas_cnt[0] <= 5'h00;
      meas_cnt[1] <= 5'h00;
      for (int i = 0; i < SYNC_NODE_LIMIT; i++) begin
        meas[0][i] <= '0;
        meas[1][i] <= '0;
      end
    end else if (i_nit_start) begin
      meas_cnt[!i_cycle_odd] <= 5'h00;
      for (int i = 0; i < SYNC_NODE_LIMIT; i++) begin
        meas[!i_cycle_odd][i] <= '0;
      end
    end else if (i_meas_valid && meas_cnt[i_cycle_odd] < 5'(SYNC_NODE_LIMIT)) begin
      meas[i_cycle_odd][meas_cnt[i_cycle_odd][3:0]] <= i_meas_value;
      meas_cnt[i_cycle_odd] <= meas_cnt[i_cycle_odd] + 5'h01;
    end
  end

  // correction terms: limit first, external term added afterwards
  assign corr_err = i_corr_calc && su_max != 5'h00
    && (lim_chk(i_offs_raw, offs_lim) != i_offs_raw || lim_chk(i_rate_raw, rate_lim) != i_rate_raw);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_offs_corr <= 16'h0000;
      o_rate_corr <= 16'h0000;
    end else if (i_corr_calc && su_max != 5'h00) begin
      o_offs_corr <= lim_chk(i_offs_raw, offs_lim) + ext_offs;
      o_rate_corr <= lim_chk(i_rate_raw, rate_lim) + ext_rate;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || i_mt_reset) begin
      mt_value <= 16'h0000;
    end else if (i_mt_tick) begin
      mt_value <= mt_value + 16'h0001;
    end
  end

  // sticky status; a read clears only the bits it returned, so a late event is not lost
  assign irq_set = {rx_ok, wake_done, corr_err | cfg_err, timer_hit};
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_stat <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= ((rd_en && i_paddr == OFS_IRQ_STAT) ? (irq_stat & ~o_prdata[3:0]) : irq_stat) | irq_set;
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_last_fail;
    last_fail && cmd == 3'h0 ##1 !i_integrated && cmd == 3'h0;
  endsequence
  sequence s_shown_then_int;
    (o_state == ST_CS_LISTEN && state == ST_INT_LISTEN) ##1 (o_state inside {ST_CS_LISTEN, ST_INT_LISTEN});
  endsequence

  chk_wake_to_config: assert property (wake_done |=> state == ST_CONFIG)
    else $error("wake send did not return to config");
  chk_inhibit_sticky: assert property (state != ST_PROT_RESET && o_coldstart_inhibit |=> o_coldstart_inhibit)
    else $error("coldstart inhibit cleared after reset state");
  chk_startup_no_rx: assert property (startup_phase |=> !o_rx_buf_we && !o_rx_fifo_we)
    else $error("frame delivered during startup");
  chk_null_dropped: assert property (i_rx_valid && !i_rx_null_ind |=> !o_rx_buf_we && !o_rx_fifo_we)
    else $error("null frame delivered");
  chk_cs_listen_shown: assert property (s_last_fail |-> s_shown_then_int)
    else $error("coldstart listen not shown after last failed attempt");
  chk_init_sched_hold: assert property (state == ST_INIT_SCHED && !i_cycle_start && cmd != CMD_CONFIG
    |=> state == ST_INIT_SCHED)
    else $error("schedule initialisation left mid cycle");
  chk_mt_zero: assert property (i_mt_reset |=> mt_value == 16'h0000)
    else $error("host macrotick not zeroed");
  chk_meas_limit: assert property (meas_cnt[0] <= 5'h10 && meas_cnt[1] <= 5'h10)
    else $error("more than sixteen sync measurements stored");
  chk_idle_min: assert property (o_idle_len >= IDLE_MIN)
    else $error("idle interval length below minimum");
  chk_timer_irq: assert property (timer_hit && irq_mask[IRQ_TIMER] |=> irq_stat[IRQ_TIMER] ##1 o_irq)
    else $error("timer interrupt not raised");
endmodule // ttpc_core

// ### bench/ttpc_far_node.sv
// ttpc_far_node: far nodes and transceivers handing received frames to the core
`timescale 1ns/1ns
module ttpc_far_node (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [2:0] i_hdr,
  input wire logic i_chan,
  input wire logic [10:0] i_fid,
  input wire logic [31:0] i_data,
  output logic o_rx_valid,
  output logic o_rx_chan,
  output logic o_rx_startup_ind,
  output logic o_rx_sync_ind,
  output logic o_rx_null_ind,
  output logic [10:0] o_rx_frame_id,
  output logic [5:0] o_rx_cycle,
  output logic [15:0] o_rx_msg_id,
  output logic [31:0] o_rx_data
);
  initial begin
    {o_rx_valid, o_rx_chan, o_rx_startup_ind, o_rx_sync_ind, o_rx_null_ind} = 5'h00;
    {o_rx_frame_id, o_rx_cycle, o_rx_msg_id, o_rx_data} = '0;
  end
  // between frames the lines flip every cycle so a stale copy can never look valid
  always @(posedge i_clk) begin
    o_rx_valid <= i_go;
    if (i_go) begin
      {o_rx_startup_ind, o_rx_sync_ind, o_rx_null_ind} <= i_hdr;
      o_rx_chan <= i_chan;
      o_rx_frame_id <= i_fid;
      o_rx_cycle <= 6'h00;
      o_rx_msg_id <= 16'h0000;
      o_rx_data <= i_data;
    end else begin
      {o_rx_chan, o_rx_frame_id, o_rx_cycle, o_rx_msg_id, o_rx_data} <=
        ~{o_rx_chan, o_rx_frame_id, o_rx_cycle, o_rx_msg_id, o_rx_data};
      {o_rx_startup_ind, o_rx_sync_ind, o_rx_null_ind} <= ~{o_rx_startup_ind, o_rx_sync_ind, o_rx_null_ind};
    end
  end
endmodule // ttpc_far_node

// ### bench/tb_time_triggered_protocol_core.sv
// tb_time_triggered_protocol_core: self-checking bench of the protocol core
`timescale 1ns/1ns
module tb_time_triggered_protocol_core;
  import ttpc_pkg::*;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, go = 0, gch = 0, odd = 0;
  logic [7:0] paddr = 8'h00, pul = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, gdat = 32'h0000_0000;
  logic [2:0] ghdr = 3'h0;
  logic [10:0] gfid = 11'h000;
  logic [15:0] offs_raw = 16'h0000, rate_raw = 16'h0000, mval = 16'h0000;
  logic rv, rch, rst_i, rsy, rnul, pready, pslverr, irq, wa, wb, bwe, fwe, inh;
  logic [10:0] rfid, ofid;
  logic [5:0] rcyc;
  logic [15:0] rmid, ocorr, rcorr, idle;
  logic [31:0] rdat, prdata, odat;
  logic [33:0] ea;
  logic [42:0] ef;
  ttpc_state_e st;
  logic [33:0] q_apb[$];
  logic [42:0] q_rx[$];
  int error_cnt = 0, n_checks = 0, n, c;
  always #5 clk = ~clk;
  ttpc_far_node far (.i_clk(clk), .i_go(go), .i_hdr(ghdr), .i_chan(gch), .i_fid(gfid), .i_data(gdat),
    .o_rx_valid(rv), .o_rx_chan(rch), .o_rx_startup_ind(rst_i), .o_rx_sync_ind(rsy), .o_rx_null_ind(rnul),
    .o_rx_frame_id(rfid), .o_rx_cycle(rcyc), .o_rx_msg_id(rmid), .o_rx_data(rdat));
  ttpc_core DUT (.i_mclk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .i_cycle_start(pul[0]), .i_cycle_odd(odd), .i_nit_start(pul[1]),
    .i_mt_tick(pul[2]), .i_mt_reset(pul[3]), .i_rx_valid(rv), .i_rx_chan(rch), .i_rx_startup_ind(rst_i),
    .i_rx_sync_ind(rsy), .i_rx_null_ind(rnul), .i_rx_frame_id(rfid), .i_rx_cycle(rcyc), .i_rx_msg_id(rmid),
    .i_rx_data(rdat), .i_meas_valid(pul[7]), .i_meas_value(mval), .i_coldstart_fail(pul[6]),
    .i_integrated(pul[4]), .i_corr_calc(pul[5]), .i_offs_raw(offs_raw), .i_rate_raw(rate_raw),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_wake_tx_a(wa),
    .o_wake_tx_b(wb), .o_rx_buf_we(bwe), .o_rx_fifo_we(fwe), .o_rx_frame_id(ofid), .o_rx_data(odat),
    .o_offs_corr(ocorr), .o_rate_corr(rcorr), .o_idle_len(idle), .o_coldstart_inhibit(inh), .o_state(st));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bit 33 asks for a data compare, bit 32 is the expected error response
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    q_apb.push_back(e);
    psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    psel <= 1'b0; pen <= 1'b0;
    // one idle edge keeps a following call from reassigning psel in the same time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {2'b10, e});
  endtask
  task automatic pulse(input int k);
    pul[k] <= 1'b1;
    @(posedge clk);
    pul <= 8'h00;
    @(posedge clk);
  endtask
  task automatic frame(input logic ch, input logic [2:0] h, input logic [10:0] f, input logic ok);
    gdat <= $urandom; gch <= ch; ghdr <= h; gfid <= f; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    if (ok) q_rx.push_back({f, gdat});
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) if (psel && pen && pready === 1'b1) begin
    ea = q_apb.size() ? q_apb.pop_front() : 'x;
    chk(pslverr, ea[32]);
    if (ea[33]) chk(prdata, ea[31:0]);
  end
  always @(posedge clk) if (bwe === 1'b1 || fwe === 1'b1) begin
    ef = q_rx.size() ? q_rx.pop_front() : 'x;
    chk(ofid, ef[42:32]);
    chk(odat, ef[31:0]);
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(32'hd407_bd93));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(st, ST_PROT_RESET);
    chk(idle, 32'h0000_0010);
    rd(OFS_CTRL, 32'h0000_0822);
    apb(1'b0, 8'hFC, 32'h0000_0000, 34'h3_0000_0000);
    wr(OFS_IDLE, 32'h0000_0003);
    rd(OFS_IDLE, 32'h0000_0010);
    chk(irq, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0000_0001);
    rd(OFS_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0000_0000);
    wr(OFS_IDLE, 32'h0000_0008);
    chk(idle, 32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_0817);
    wr(OFS_CMD, {29'h0, CMD_CONFIG});
    wr(OFS_CTRL, 32'h0000_0816);
    chk(inh, 32'h0000_0001);
    rd(OFS_CTRL, 32'h0000_0817);
    wr(OFS_CMD, {29'h0, CMD_READY});
    wr(OFS_CMD, {29'h0, CMD_WAKEUP});
    n = 0;
    c = 0;
    while (st !== ST_CONFIG && n < 3000) begin
      @(posedge clk);
      n++;
      if (wa === 1'b1 && wb === 1'b1) c++;
    end
    chk(c, WAKE_LOW_CYC);
    chk(st, ST_CONFIG);
    wr(OFS_CMD, {29'h0, CMD_READY});
    wr(OFS_CMD, {29'h0, CMD_RUN});
    @(posedge clk);
    chk(st, ST_INT_LISTEN);
    frame(1'b0, 3'b001, 11'h025, 1'b0);
    pulse(4);
    chk(st, ST_INIT_SCHED);
    frame(1'b1, 3'b011, 11'h026, 1'b0);
    chk(st, ST_INIT_SCHED);
    pulse(0);
    chk(st, ST_NORMAL);
    frame(1'b1, 3'b111, 11'h031, 1'b1);
    frame(1'b0, 3'b000, 11'h032, 1'b0);
    wr(OFS_OFFS_LIM, 32'h0000_0010);
    wr(OFS_EXT_OFFS, 32'h0000_0002);
    wr(OFS_EXT_RATE, 32'h0000_0005);
    offs_raw <= 16'h0100;
    rate_raw <= 16'hF000;
    pulse(5);
    chk(ocorr, 32'h0000_0012);
    chk(rcorr, 32'h0000_FF05);
    repeat (3) pulse(2);
    rd(OFS_MT, 32'h0000_0003);
    pulse(3);
    rd(OFS_MT, 32'h0000_0000);
    wr(OFS_MEAS_SEL, 32'h0000_0000);
    mval <= 16'($urandom);
    pulse(7);
    rd(OFS_MEAS_DATA, {16'h0000, mval});
    pulse(1);
    rd(OFS_MEAS_DATA, {16'h0000, mval});
    odd <= 1'b1;
    pulse(1);
    rd(OFS_MEAS_DATA, 32'h0000_0000);
    // second reset in mid-run: inhibit clear is allowed again, last coldstart attempt fails
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(st, ST_PROT_RESET);
    wr(OFS_CTRL, 32'h0000_0108);
    chk(inh, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_CMD, {29'h0, CMD_CONFIG});
    wr(OFS_CMD, {29'h0, CMD_READY});
    wr(OFS_CMD, {29'h0, CMD_RUN});
    chk(st, ST_CS_LISTEN);
    pulse(6);
    chk(st, ST_CS_LISTEN);
    pulse(2);
    chk(st, ST_INT_LISTEN);
    @(posedge clk);
    chk(irq, 32'h0000_0001);
    pulse(4);
    pulse(0);
    chk(st, ST_NORMAL);
    frame(1'b0, 3'b001, 11'h040, 1'b1);
    wr(OFS_MID_FILT, 32'h0001_0001);
    frame(1'b0, 3'b001, 11'h041, 1'b0);
    repeat (5) @(posedge clk);
    chk(q_apb.size() + q_rx.size(), 32'h0000_0000);
    conclude();
  end
endmodule // tb_time_triggered_protocol_core
